// >>> verilog/chs_rail_sel.sv
// class h rail selector: picks the charge pump rail set for the hp amplifiers
// Operation
// - four rail modes: 2.5v, full, half, third
// - policy 001..100 forces mode 0..3
// - fixed policy ignores signal level
// - policy 111 picks rail from clip test
// - possible clip raises the rail straight to the set the sample needs
// - no clip requests lower rail set
// - upward change on next pump clock cycle
// - downward change after 5.5 s hold-off
// - 15 ohm thresholds -8/-14/-20 db, 10nf -9/-14/-19 db
// - 30 ohm thresholds -4/-11/-16 db
// - 3 kohm thresholds -1/-8/-13 db
// - thresholds follow monitored load conditions
// - thresholds relative to 0 db full scale
module chs_rail_sel
    import chs_pkg::*;
#(
    // down-step hold-off in core clock cycles
    parameter logic [CHS_HOLD_W-1:0] HOLDOFF_CYCLES = CHS_HOLD_W'(CHS_HOLDOFF_CYC)
) (
    // clock and reset
    input  logic                    core_clk_i,
    input  logic                    rst_n_i,
    // policy control
    input  logic [2:0]              rail_policy_sel_i,
    input  logic                    full_scale_attenuation_i,
    // outgoing signal to the amplifiers
    input  logic [CHS_SAMPLE_W-1:0] sample_i,
    input  logic                    sample_valid_i,
    // monitored amplifier load conditions
    input  logic [1:0]              load_res_i,
    input  logic                    load_cap_high_i,
    // charge pump
    input  logic                    pump_flying_cap_clock_i,
    output logic [1:0]              rail_mode_o,
    // status
    output logic                    adaptive_active_o,
    output logic                    up_pending_o,
    output logic                    holdoff_active_o
);

    // control states, one-hot
    typedef enum logic [2:0] {
        ST_STEADY = 3'b001,  // rail matches need
        ST_UP     = 3'b010,  // waiting for pump edge to raise rail
        ST_DOWN   = 3'b100   // hold-off running before lowering rail
    } chs_state_e;

    // all state of the controller
    typedef struct packed {
        chs_state_e st;         // control state
        logic [1:0] mode;       // applied rail mode
        logic [1:0] up_tgt;     // pending higher rail mode
        logic [1:0] down_tgt;   // rail mode to drop to after hold-off
        logic       pump_prev;  // last pump clock level
        logic       adapt;      // adaptive policy in force
    } chs_ctl_s;

    chs_ctl_s q, d;

    // internal carrier
    chs_ctl_if ctl_bus ();

    // combinational helpers
    logic       pump_edge;  // rising edge of the pump clock
    logic [1:0] fixed_mode; // mode forced by a fixed policy
    logic       is_fixed;   // policy is one of the fixed codes

    // level detector: needed mode per sample
    chs_level_det u_det (
        .core_clk_i              (core_clk_i),
        .rst_n_i                 (rst_n_i),
        .sample_i                (sample_i),
        .sample_valid_i          (sample_valid_i),
        .load_res_i              (load_res_i),
        .load_cap_high_i         (load_cap_high_i),
        .full_scale_attenuation_i(full_scale_attenuation_i),
        .lvl                     (ctl_bus.det)
    );

    // hold-off timer for downward steps
    chs_holdoff #(
        .HOLD_CYC(HOLDOFF_CYCLES)
    ) u_hold (
        .core_clk_i(core_clk_i),
        .rst_n_i   (rst_n_i),
        .tmr       (ctl_bus.tmr)
    );

    // timer runs only while a lower rail is being waited for
    assign ctl_bus.hold_run = (q.st == ST_DOWN);

    // policy decode
    always_comb begin
        is_fixed   = 1'b1;
        fixed_mode = q.mode;
        // fixed codes map onto the four rail modes
        unique case (rail_policy_sel_i)
            CHS_POL_FIX0: fixed_mode = CHS_MODE_2V5;
            CHS_POL_FIX1: fixed_mode = CHS_MODE_FULL;
            CHS_POL_FIX2: fixed_mode = CHS_MODE_HALF;
            CHS_POL_FIX3: fixed_mode = CHS_MODE_THIRD;
            default:      is_fixed   = 1'b0;
        endcase
    end

    // pump clock edge, input is synchronous to the core clock
    assign pump_edge = pump_flying_cap_clock_i & ~q.pump_prev;

    // next-state logic
    always_comb begin
        d           = q;
        d.pump_prev = pump_flying_cap_clock_i;

        if (is_fixed) begin
            // fixed rail, signal level is not looked at
            d.st    = ST_STEADY;
            d.adapt = 1'b0;
            // new fixed setting reaches the pump on its clock
            if (pump_edge) begin
                d.mode = fixed_mode;
            end
        end else if (rail_policy_sel_i == CHS_POL_ADAPT) begin
            // adaptive: rail follows the clip test only
            d.adapt = 1'b1;
            if (!q.adapt) begin
                // fresh entry, judge from the next sample
                d.st = ST_STEADY;
            end else begin
                unique case (q.st)
                    ST_STEADY: begin
                        if (ctl_bus.need_valid) begin
                            if (ctl_bus.need_mode < q.mode) begin
                                // clip possible on present rail
                                d.up_tgt = ctl_bus.need_mode;
                                d.st     = ST_UP;
                            end else if (ctl_bus.need_mode > q.mode) begin
                                // lower set would not clip
                                d.down_tgt = ctl_bus.need_mode;
                                d.st       = ST_DOWN;
                            end
                        end
                    end
                    ST_UP: begin
                        // a louder sample while waiting raises the target
                        if (ctl_bus.need_valid && (ctl_bus.need_mode < q.up_tgt)) begin
                            d.up_tgt = ctl_bus.need_mode;
                        end
                        // raise on the very next pump clock cycle
                        if (pump_edge) begin
                            d.mode = d.up_tgt;
                            d.st   = ST_STEADY;
                        end
                    end
                    ST_DOWN: begin
                        if (ctl_bus.need_valid && (ctl_bus.need_mode < q.mode)) begin
                            // transient needs more rail, abandon the drop
                            d.up_tgt = ctl_bus.need_mode;
                            d.st     = ST_UP;
                        end else if (ctl_bus.need_valid && (ctl_bus.need_mode == q.mode)) begin
                            // signal back at present rail, hold-off restarts
                            d.st = ST_STEADY;
                        end else begin
                            // keep the drop shallow enough for every sample seen
                            if (ctl_bus.need_valid && (ctl_bus.need_mode < q.down_tgt)) begin
                                d.down_tgt = ctl_bus.need_mode;
                            end
                            // hold-off elapsed, lower the rail
                            if (ctl_bus.hold_expired) begin
                                d.mode = d.down_tgt;
                                d.st   = ST_STEADY;
                            end
                        end
                    end
                    default: begin
                        // illegal code, fall back to steady
                        d.st = ST_STEADY;
                    end
                endcase
            end
        end else begin
            // reserved policy: rail and state stay as they are
            d.adapt = q.adapt;
        end
    end

    // state register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{st: ST_STEADY, mode: CHS_MODE_RST, up_tgt: CHS_MODE_RST,
                   down_tgt: CHS_MODE_RST, pump_prev: 1'b0, adapt: 1'b0};
        end else begin
            q <= d;
        end
    end

    // outputs, mode and adaptive flag from flip-flops, pending and hold-off flags decoded from the state register
    assign rail_mode_o       = q.mode;
    assign adaptive_active_o = q.adapt;
    assign up_pending_o      = (q.st == ST_UP);
    assign holdoff_active_o  = (q.st == ST_DOWN);

endmodule // chs_rail_sel

// >>> verilog/chs_pkg.sv
// shared constants and helpers of the class h rail selector
package chs_pkg;

    // rail mode codes, 0 is the highest rail set
    localparam logic [1:0] CHS_MODE_2V5   = 2'h0;  // fixed 2.5 v rails
    localparam logic [1:0] CHS_MODE_FULL  = 2'h1;  // full pump input supply
    localparam logic [1:0] CHS_MODE_HALF  = 2'h2;  // half pump input supply
    localparam logic [1:0] CHS_MODE_THIRD = 2'h3;  // third of pump input supply
    localparam logic [1:0] CHS_MODE_RST   = CHS_MODE_2V5;  // mode after reset

    // rail policy codes
    localparam logic [2:0] CHS_POL_FIX0  = 3'h1;  // hold mode 0
    localparam logic [2:0] CHS_POL_FIX1  = 3'h2;  // hold mode 1
    localparam logic [2:0] CHS_POL_FIX2  = 3'h3;  // hold mode 2
    localparam logic [2:0] CHS_POL_FIX3  = 3'h4;  // hold mode 3
    localparam logic [2:0] CHS_POL_ADAPT = 3'h7;  // adapt to signal

    // load resistance classes reported by the supply monitor
    localparam logic [1:0] CHS_LOAD_15R = 2'h0;  // 15 ohm
    localparam logic [1:0] CHS_LOAD_30R = 2'h1;  // 30 ohm
    localparam logic [1:0] CHS_LOAD_3K  = 2'h2;  // 3 kohm

    // sample and magnitude layout
    localparam int         CHS_SAMPLE_W = 24;      // signed full scale sample
    localparam int         CHS_MAG_LSB  = 7;       // lowest sample bit kept in magnitude
    localparam logic [15:0] CHS_MAG_SAT = 16'hffff; // saturated magnitude

    // thresholds as fraction of full scale, q0.16
    localparam logic [15:0] CHS_THR_M1DB  = 16'he429;  // -1 db
    localparam logic [15:0] CHS_THR_M4DB  = 16'ha186;  // -4 db
    localparam logic [15:0] CHS_THR_M8DB  = 16'h65ea;  // -8 db
    localparam logic [15:0] CHS_THR_M9DB  = 16'h5ad5;  // -9 db
    localparam logic [15:0] CHS_THR_M11DB = 16'h4827;  // -11 db
    localparam logic [15:0] CHS_THR_M13DB = 16'h3950;  // -13 db
    localparam logic [15:0] CHS_THR_M14DB = 16'h3314;  // -14 db
    localparam logic [15:0] CHS_THR_M16DB = 16'h2893;  // -16 db
    localparam logic [15:0] CHS_THR_M19DB = 16'h1cb9;  // -19 db
    localparam logic [15:0] CHS_THR_M20DB = 16'h199a;  // -20 db

    // down-step hold-off
    localparam longint CHS_CLK_HZ     = 100000000;  // core clock rate
    localparam longint CHS_HOLDOFF_MS = 5500;       // 5.5 s hysteresis
    localparam longint CHS_HOLDOFF_CYC = CHS_HOLDOFF_MS * CHS_CLK_HZ / 1000;
    localparam int     CHS_HOLD_W     = 32;         // hold-off counter width

    // lower bound of the level range of rail mode idx (0..2)
    function automatic logic [15:0] chs_thr(input logic [1:0] res, input logic cap_hi, input logic [1:0] idx);
        logic [15:0] t;
        t = CHS_THR_M20DB;
        unique case (res)
            CHS_LOAD_30R: t = (idx == 2'h0) ? CHS_THR_M4DB : (idx == 2'h1) ? CHS_THR_M11DB : CHS_THR_M16DB;
            CHS_LOAD_3K:  t = (idx == 2'h0) ? CHS_THR_M1DB : (idx == 2'h1) ? CHS_THR_M8DB : CHS_THR_M13DB;
            default: begin
                if (cap_hi) begin
                    t = (idx == 2'h0) ? CHS_THR_M9DB : (idx == 2'h1) ? CHS_THR_M14DB : CHS_THR_M19DB;
                end else begin
                    t = (idx == 2'h0) ? CHS_THR_M8DB : (idx == 2'h1) ? CHS_THR_M14DB : CHS_THR_M20DB;
                end
            end
        endcase
        return t;
    endfunction

endpackage

// >>> verilog/chs_ctl_if.sv
// internal carrier between rail control, level detector and hold-off timer
interface chs_ctl_if;
    logic [1:0] need_mode;     // highest-number mode that does not clip the last sample
    logic       need_valid;    // one-cycle pulse per evaluated sample
    logic       hold_run;      // hold-off timer runs while high
    logic       hold_expired;  // hold-off elapsed, level

    // level detector side
    modport det (output need_mode, output need_valid);
    // hold-off timer side
    modport tmr (input hold_run, output hold_expired);
    // rail control side
    modport ctl (input need_mode, input need_valid, input hold_expired, output hold_run);
endinterface

// >>> verilog/chs_level_det.sv
// signal level to needed rail mode comparator
module chs_level_det
    import chs_pkg::*;
(
    // clock and reset
    input  logic                    core_clk_i,
    input  logic                    rst_n_i,
    // outgoing signal
    input  logic [CHS_SAMPLE_W-1:0] sample_i,
    input  logic                    sample_valid_i,
    // load and scale conditions
    input  logic [1:0]              load_res_i,
    input  logic                    load_cap_high_i,
    input  logic                    full_scale_attenuation_i,
    // result
    chs_ctl_if.det                  lvl
);

    typedef struct packed {
        logic [1:0] need;   // needed mode
        logic       valid;  // result strobe
    } chs_det_s;

    chs_det_s q, d;
    logic [CHS_SAMPLE_W-1:0] mag;    // absolute value
    logic [15:0]             mag16;  // scaled magnitude

    // magnitude, threshold compare against load dependent table
    always_comb begin
        d       = q;
        mag     = sample_i[CHS_SAMPLE_W-1] ? (~sample_i + 1'b1) : sample_i;
        mag16   = mag[CHS_SAMPLE_W-1] ? CHS_MAG_SAT : mag[CHS_SAMPLE_W-2:CHS_MAG_LSB];
        // thresholds hold at 0 db scale; a -6 db setting halves the level seen
        if (full_scale_attenuation_i) begin
            mag16 = {1'b0, mag16[15:1]};
        end
        d.valid = sample_valid_i;
        if (sample_valid_i) begin
            // lowest rail set that does not clip
            if (mag16 >= chs_thr(load_res_i, load_cap_high_i, 2'h0)) begin
                d.need = CHS_MODE_2V5;
            end else if (mag16 >= chs_thr(load_res_i, load_cap_high_i, 2'h1)) begin
                d.need = CHS_MODE_FULL;
            end else if (mag16 >= chs_thr(load_res_i, load_cap_high_i, 2'h2)) begin
                d.need = CHS_MODE_HALF;
            end else begin
                d.need = CHS_MODE_THIRD;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{need: CHS_MODE_RST, valid: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign lvl.need_mode  = q.need;
    assign lvl.need_valid = q.valid;

endmodule // chs_level_det

// >>> verilog/chs_holdoff.sv
// hold-off timer for downward rail steps
module chs_holdoff
    import chs_pkg::*;
#(
    parameter logic [CHS_HOLD_W-1:0] HOLD_CYC = CHS_HOLD_W'(CHS_HOLDOFF_CYC)  // cycles to wait
) (
    // clock and reset
    input  logic   core_clk_i,
    input  logic   rst_n_i,
    // control
    chs_ctl_if.tmr tmr
);

    typedef struct packed {
        logic [CHS_HOLD_W-1:0] cnt;  // elapsed cycles
        logic                  exp;  // elapsed flag
    } chs_hold_s;

    chs_hold_s q, d;

    // count while run is high, restart from zero when it drops
    always_comb begin
        d = q;
        if (!tmr.hold_run) begin
            d.cnt = '0;
            d.exp = 1'b0;
        end else if (q.cnt == HOLD_CYC - 1'b1) begin
            d.exp = 1'b1;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{cnt: '0, exp: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign tmr.hold_expired = q.exp;

endmodule // chs_holdoff

// >>> tb/chs_rail_sel_assertions.sv
// port-level checks of the class h rail selector
module chs_rail_sel_assertions
    import chs_pkg::*;
#(
    parameter logic [CHS_HOLD_W-1:0] HOLDOFF_CYCLES = 32'h14  // down-step hold-off
) (
    // clock and reset
    input logic       core_clk_i,
    input logic       rst_n_i,
    // policy and pump clock
    input logic [2:0] rail_policy_sel_i,
    input logic       pump_flying_cap_clock_i,
    // outputs watched
    input logic [1:0] rail_mode_o,
    input logic       adaptive_active_o,
    input logic       up_pending_o,
    input logic       holdoff_active_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    logic                  fix;     // fixed policy code present
    logic                  rsv;     // reserved policy code present
    logic [CHS_HOLD_W-1:0] hold_q;  // consecutive hold-off cycles
    logic [CHS_HOLD_W-1:0] hold_d;  // next hold-off count

    assign fix = rail_policy_sel_i inside {[3'h1:3'h4]};
    assign rsv = !fix && (rail_policy_sel_i != CHS_POL_ADAPT);

    // count how long the hold-off has run without a break
    always_comb hold_d = holdoff_active_o ? hold_q + 1'b1 : '0;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) hold_q <= '0;
        else hold_q <= hold_d;
    end

    property p_reset_mode;
        $rose(rst_n_i) |-> rail_mode_o == CHS_MODE_RST && !up_pending_o && !holdoff_active_o;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("rail mode wrong after reset");
    property p_fixed_apply;
        (fix && $stable(rail_policy_sel_i)) [*8] ##0 $rose(pump_flying_cap_clock_i)
            |-> ##[1:2] rail_mode_o == rail_policy_sel_i[1:0] - 2'h1;
    endproperty
    a_fixed_apply: assert property (p_fixed_apply) else $error("fixed mode not applied");
    property p_fixed_hold;
        fix && $stable(rail_policy_sel_i) && rail_mode_o == rail_policy_sel_i[1:0] - 2'h1 |=> $stable(rail_mode_o);
    endproperty
    a_fixed_hold: assert property (p_fixed_hold) else $error("fixed rail moved");
    property p_fixed_flags;
        fix [*2] |-> !adaptive_active_o && !holdoff_active_o;
    endproperty
    a_fixed_flags: assert property (p_fixed_flags) else $error("adaptive state in fixed policy");
    property p_adapt_flag;
        rail_policy_sel_i == CHS_POL_ADAPT |=> adaptive_active_o;
    endproperty
    a_adapt_flag: assert property (p_adapt_flag) else $error("adaptive flag missing");
    property p_up_cause;
        adaptive_active_o && $past(adaptive_active_o) && rail_mode_o < $past(rail_mode_o) |-> $past(up_pending_o);
    endproperty
    a_up_cause: assert property (p_up_cause) else $error("rail raised without request");
    property p_up_step;
        rail_policy_sel_i == CHS_POL_ADAPT && up_pending_o && $rose(pump_flying_cap_clock_i)
            |=> rail_mode_o < $past(rail_mode_o);
    endproperty
    a_up_step: assert property (p_up_step) else $error("raise missed pump cycle");
    property p_up_bound;
        rail_policy_sel_i == CHS_POL_ADAPT && up_pending_o |-> ##[0:40] !up_pending_o;
    endproperty
    a_up_bound: assert property (p_up_bound) else $error("raise pending too long");
    property p_down_wait;
        adaptive_active_o && $past(adaptive_active_o) && rail_mode_o > $past(rail_mode_o)
            |-> $past(hold_q) >= HOLDOFF_CYCLES - 2;
    endproperty
    a_down_wait: assert property (p_down_wait) else $error("rail lowered before hold-off");
    property p_rsv_freeze;
        rsv [*2] |=> $stable(rail_mode_o);
    endproperty
    a_rsv_freeze: assert property (p_rsv_freeze) else $error("rail moved in reserved policy");
endmodule  // chs_rail_sel_assertions

bind chs_rail_sel chs_rail_sel_assertions #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) u_chk (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .rail_policy_sel_i(rail_policy_sel_i),
    .pump_flying_cap_clock_i(pump_flying_cap_clock_i), .rail_mode_o(rail_mode_o),
    .adaptive_active_o(adaptive_active_o), .up_pending_o(up_pending_o), .holdoff_active_o(holdoff_active_o));

// >>> tb/chs_pump_model.sv
// free running charge pump flying capacitor clock source
module chs_pump_model (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // pace select, 1 = slow pump
    input  wire logic slow_i,
    // pump clock to the selector
    output logic      pump_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] div_q;  // half period divider

    // toggle every 3 core cycles, or every 8 when slow
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= 4'h0;
            pump_clk_o <= 1'b0;
        end else if (div_q >= (slow_i ? 4'h7 : 4'h2)) begin
            div_q <= 4'h0;
            pump_clk_o <= !pump_clk_o;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end
endmodule  // chs_pump_model

// >>> tb/tb.sv
// self-checking testbench of the class h rail selector
module tb
    import chs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [CHS_HOLD_W-1:0] HOLD = 32'h14;  // short hold-off for sim

    logic                    core_clk_i = 1'b0;
    logic                    rst_n_i    = 1'b0;
    logic [2:0]              pol        = CHS_POL_FIX0;  // rail policy
    logic                    fsa        = 1'b0;          // full scale attenuation
    logic [CHS_SAMPLE_W-1:0] smp        = '0;            // sample to amplifiers
    logic                    valid      = 1'b0;
    logic [1:0]              res        = CHS_LOAD_15R;  // load class
    logic                    cap        = 1'b0;          // 10 nf load
    logic                    slow       = 1'b0;          // slow pump pace
    logic                    pump;
    logic [1:0]              mode, mode_w;            // settled copy, design output
    logic                    adapt, upp, hoff;        // settled copies of the flags
    logic                    adapt_w, upp_w, hoff_w;  // design flag outputs
    int                      n_fail = 0, compares = 0, cyc = 0;
    real                     thr [4][3] = '{'{-8.0, -14.0, -20.0}, '{-9.0, -14.0, -19.0},
                                            '{-4.0, -11.0, -16.0}, '{-1.0, -8.0, -13.0}};
    logic [1:0]              lres [4]   = '{CHS_LOAD_15R, CHS_LOAD_15R, CHS_LOAD_30R, CHS_LOAD_3K};

    chs_pump_model u_pump (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .pump_clk_o(pump));
    chs_rail_sel #(.HOLDOFF_CYCLES(HOLD)) u_dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .rail_policy_sel_i(pol),
        .full_scale_attenuation_i(fsa), .sample_i(smp), .sample_valid_i(valid),
        .load_res_i(res), .load_cap_high_i(cap), .pump_flying_cap_clock_i(pump),
        .rail_mode_o(mode_w), .adaptive_active_o(adapt_w), .up_pending_o(upp_w), .holdoff_active_o(hoff_w));

    // clock and cycle count
    initial forever #5 core_clk_i = !core_clk_i;
    always @(posedge core_clk_i) cyc <= cyc + 1;
    // outputs are read from copies taken mid-cycle, clear of the launching edge
    always @(negedge core_clk_i) {mode, adapt, upp, hoff} <= {mode_w, adapt_w, upp_w, hoff_w};

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // one sample pulse, then one idle cycle
    task automatic send(input logic [CHS_SAMPLE_W-1:0] v);
        @(posedge core_clk_i);
        smp <= v;
        valid <= 1'b1;
        @(posedge core_clk_i);
        valid <= 1'b0;
    endtask
    task automatic quiet(input int n);
        repeat (n) send(24'h0);
    endtask
    // sample k times the level of db below full scale
    function automatic logic [CHS_SAMPLE_W-1:0] lvl(input real db, input real k, input bit neg);
        int a;
        a = int'(k * 8388608.0 * 10.0 ** (db / 20.0));
        return neg ? 24'(-a) : 24'(a);
    endfunction
    task automatic complete_run();
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic t_reset();
        step(2);
        check("reset state", {mode, adapt, upp, hoff}, 0);
    endtask
    // every fixed code, loud samples must not move the rail
    task automatic t_fixed();
        int fc [4] = '{2, 4, 1, 3};
        foreach (fc[i]) begin
            pol <= 3'(fc[i]);
            repeat (12) send(24'h7fffff);
            check("fixed mode", mode, fc[i] - 1);
            check("fixed flags", {adapt, hoff}, 0);
        end
    endtask
    // reserved codes keep mode 2 despite loud samples
    task automatic t_reserved();
        logic [2:0] rc [3] = '{3'h0, 3'h5, 3'h6};
        foreach (rc[i]) begin
            pol <= rc[i];
            repeat (8) send(24'h7fffff);
            check("reserved mode", mode, 2);
        end
    endtask
    // just above and just below each threshold of each load
    task automatic t_levels();
        pol <= CHS_POL_ADAPT;
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 6; j++) begin
                res <= lres[i];
                cap <= (i == 1);
                quiet(18);
                check("idle mode", mode, 3);
                check("adapt flag", adapt, 1);
                send(lvl(thr[i][j / 2], (j % 2) ? 0.98 : 1.01, j > 2));
                step(12);
                check("adapt mode", mode, j / 2 + j % 2);
            end
        end
        fsa <= 1'b1;
        quiet(18);
        send(lvl(-1.0, 1.01, 1'b0));
        step(12);
        check("attenuated mode", mode, 1);
        fsa <= 1'b0;
    endtask
    // restart of the hold-off, then a drop to the rail the loudest sample seen needs
    task automatic t_hyst();
        int t0;
        res <= CHS_LOAD_15R;
        cap <= 1'b0;
        quiet(18);
        send(24'h7fffff);
        step(12);
        check("loud mode", mode, 0);
        quiet(8);
        t0 = cyc;
        send(24'h800001);
        quiet(8);
        check("restarted hold", mode, 0);
        check("holdoff flag", hoff, 1);
        send(lvl(-20.0, 1.01, 1'b0));
        while (mode === 2'h0 && cyc - t0 < 100) send(24'h0);
        check("down mode", mode, 2);
        check("hold span", (cyc - t0 >= HOLD) && (cyc - t0 <= HOLD + 10), 1);
    endtask
    // slow pump: the raise waits for the pump cycle
    task automatic t_slow();
        logic saw;
        saw = 1'b0;
        slow <= 1'b1;
        quiet(18);
        send(24'h7fffff);
        for (int n = 0; n < 40 && mode !== 2'h0; n++) begin
            saw = saw | (upp === 1'b1);
            step(1);
        end
        check("pending seen", saw, 1);
        check("slow raise", mode, 0);
        slow <= 1'b0;
    endtask

    initial begin
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_fixed();
        t_reserved();
        t_levels();
        t_hyst();
        t_slow();
        complete_run();
    end
    // watchdog against a hang
    initial begin
        repeat (8000) @(posedge core_clk_i);
        check("watchdog", 0, 1);
        complete_run();
    end
endmodule  // tb
